// file: hw/stkp_defines.vh
// constants for the system and user stack pointer block
// assumes inclusion by the stack pointer design files only
`ifndef STKP_DEFINES_VH
`define STKP_DEFINES_VH
`define STKP_CFG_UST_PAGE    8'h05
`define STKP_CFG_UST_LOC     8'h06
`define STKP_IN_USP_PAGE     8'h0B
`define STKP_IN_USP_LOC      8'h0C
`define STKP_CFG_SSP_PAGE    8'h2C
`define STKP_CFG_SSP_LOC     8'h2D
`define STKP_RAM_PAGE        8'h20
`define STKP_SSP_RST         8'hFF
`define STKP_USP_RST         8'h00
`define STKP_UST_PAGE_RST    8'h20
`define STKP_SSP_STEP        8'h02
`define STKP_FLAG_DEPTH      8
`define STKP_FLAG_PTR_W      3
`endif

// file: hw/stkp_flag_stack.v
// flag stack: one carry/sign/zero set per interrupt level
// assumes the core never nests deeper than the stack depth
`timescale 1ns/1ps
`default_nettype none
`include "stkp_defines.vh"
module stkp_flag_stack
(
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       push_i,
  input  wire       pop_i,
  input  wire [2:0] flags_i,
  output reg  [2:0] flags_o
);
  reg [2:0]                    mem [0:`STKP_FLAG_DEPTH-1];
  reg [`STKP_FLAG_PTR_W-1:0]   ptr;
  wire [`STKP_FLAG_PTR_W-1:0]  ptr_dec;
  integer                      k;

  assign ptr_dec = ptr - {{(`STKP_FLAG_PTR_W-1){1'b0}}, 1'b1};

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ptr     <= {`STKP_FLAG_PTR_W{1'b0}};
      flags_o <= 3'h0;
      for (k = 0; k < `STKP_FLAG_DEPTH; k = k + 1)
        mem[k] <= 3'h0;
    end
    else if (push_i)
    begin
      mem[ptr] <= flags_i;
      ptr      <= ptr + {{(`STKP_FLAG_PTR_W-1){1'b0}}, 1'b1};
    end
    else if (pop_i)
    begin
      flags_o <= mem[ptr_dec];
      ptr     <= ptr_dec;
    end
  end
endmodule // stkp_flag_stack
`default_nettype wire

// file: hw/stkp_top.v
// system and user stack pointers with their RAM access sequencing
// assumes a single 256-byte RAM page with one-cycle synchronous read,
// and a sequencer that waits for BUSY_O low before each new command
`timescale 1ns/1ps
`default_nettype none
`include "stkp_defines.vh"
// Summary of operation
// - call or interrupt saves PC on system stack; returns restore it
// - interrupt entry saves the flag set on an internal flag stack
// - system stack lives in the RAM page, starting at location 255
// - each system stack level takes two RAM bytes, full 16-bit PC
// - store PC at pointed pair, then lower system pointer by two
// - on return raise system pointer by two, then load PC from pair
// - system pointer page reads fixed RAM page; location byte writable
// - page byte takes 20h to FFh; every value addresses the RAM page
// - after reset user pointer low is 0, system pointer low is 255
// - push writes register byte at user pointer, then increments it
// - pop decrements user pointer, then returns the byte found there
// - writing the user stack top location also loads the user pointer
// - user pointer readable only via page and location input regs
module stkp_top
(
  input  wire        CLK_I,
  input  wire        RST_I,
  input  wire        CALL_I,
  input  wire        IRQ_I,
  input  wire        SUB_RET_I,
  input  wire        INT_RET_I,
  input  wire        PUSH_I,
  input  wire        POP_I,
  input  wire [15:0] PC_I,
  input  wire [2:0]  FLAGS_I,
  input  wire [7:0]  PUSH_DATA_I,
  input  wire        CFG_WR_I,
  input  wire [7:0]  CFG_ADDR_I,
  input  wire [7:0]  CFG_WDATA_I,
  input  wire [7:0]  CFG_RADDR_I,
  input  wire [7:0]  IN_RADDR_I,
  input  wire [7:0]  RAM_RDATA_I,
  output reg  [7:0]  CFG_RDATA_O,
  output reg  [7:0]  IN_RDATA_O,
  output reg         RAM_WE_O,
  output reg         RAM_RE_O,
  output reg  [15:0] RAM_ADDR_O,
  output reg  [7:0]  RAM_WDATA_O,
  output reg  [15:0] PC_O,
  output reg         PC_LOAD_O,
  output reg  [7:0]  POP_DATA_O,
  output reg         POP_VALID_O,
  output wire [2:0]  FLAGS_O,
  output reg         BUSY_O
);
  localparam [2:0] ST_IDLE  = 3'd0;
  localparam [2:0] ST_SAVE2 = 3'd1;
  localparam [2:0] ST_RET1  = 3'd2;
  localparam [2:0] ST_RET2  = 3'd3;
  localparam [2:0] ST_RET3  = 3'd4;
  localparam [2:0] ST_POP1  = 3'd5;
  localparam [2:0] ST_RET4  = 3'd6;
  localparam [2:0] ST_POP2  = 3'd7;

  reg [2:0]  state;
  reg [7:0]  system_stack_pointer;
  reg [7:0]  user_stack_pointer;
  reg [7:0]  ust_page;
  reg [7:0]  ust_loc;
  reg [7:0]  pc_high;
  reg [15:0] pc_hold;
  wire       flag_push;
  wire       flag_pop;

  // RAM address within the fixed page
  function [15:0] ram_addr;
    input [7:0] loc;
    begin
      ram_addr = {`STKP_RAM_PAGE, loc};
    end
  endfunction

  assign flag_push = (state == ST_IDLE) && IRQ_I;
  assign flag_pop  = (state == ST_IDLE) && !IRQ_I && !CALL_I && INT_RET_I;

  stkp_flag_stack u_flags
  (
    .clk_i   (CLK_I),
    .rst_i   (RST_I),
    .push_i  (flag_push),
    .pop_i   (flag_pop),
    .flags_i (FLAGS_I),
    .flags_o (FLAGS_O)
  );

  // stack sequencing
  always @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      state        <= ST_IDLE;
      system_stack_pointer          <= `STKP_SSP_RST;
      user_stack_pointer          <= `STKP_USP_RST;
      ust_page     <= `STKP_UST_PAGE_RST;
      ust_loc      <= `STKP_USP_RST;
      pc_high      <= 8'h00;
      pc_hold      <= 16'h0000;
      RAM_WE_O     <= 1'b0;
      RAM_RE_O     <= 1'b0;
      RAM_ADDR_O   <= 16'h0000;
      RAM_WDATA_O  <= 8'h00;
      PC_O         <= 16'h0000;
      PC_LOAD_O    <= 1'b0;
      POP_DATA_O   <= 8'h00;
      POP_VALID_O  <= 1'b0;
      BUSY_O       <= 1'b0;
    end
    else
    begin
      RAM_WE_O    <= 1'b0;
      RAM_RE_O    <= 1'b0;
      PC_LOAD_O   <= 1'b0;
      POP_VALID_O <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (IRQ_I || CALL_I)
          begin
            // low byte at pointed location, high byte just below
            RAM_WE_O    <= 1'b1;
            RAM_ADDR_O  <= ram_addr(system_stack_pointer);
            RAM_WDATA_O <= PC_I[7:0];
            pc_hold     <= PC_I;
            BUSY_O      <= 1'b1;
            state       <= ST_SAVE2;
          end
          else if (SUB_RET_I || INT_RET_I)
          begin
            system_stack_pointer          <= system_stack_pointer + `STKP_SSP_STEP;
            BUSY_O       <= 1'b1;
            state        <= ST_RET1;
          end
          else if (PUSH_I)
          begin
            RAM_WE_O    <= 1'b1;
            RAM_ADDR_O  <= ram_addr(user_stack_pointer);
            RAM_WDATA_O <= PUSH_DATA_I;
            user_stack_pointer         <= user_stack_pointer + 8'h01;
          end
          else if (POP_I)
          begin
            RAM_RE_O   <= 1'b1;
            RAM_ADDR_O <= ram_addr(user_stack_pointer - 8'h01);
            user_stack_pointer        <= user_stack_pointer - 8'h01;
            BUSY_O     <= 1'b1;
            state      <= ST_POP1;
          end
          else if (CFG_WR_I)
          begin
            if (CFG_ADDR_I == `STKP_CFG_UST_PAGE)
              ust_page <= (CFG_WDATA_I < `STKP_RAM_PAGE) ?
                          `STKP_RAM_PAGE : CFG_WDATA_I;
            else if (CFG_ADDR_I == `STKP_CFG_UST_LOC)
            begin
              ust_loc <= CFG_WDATA_I;
              user_stack_pointer     <= CFG_WDATA_I;
            end
            else if (CFG_ADDR_I == `STKP_CFG_SSP_LOC)
              system_stack_pointer <= CFG_WDATA_I;
          end
        end
        ST_SAVE2:
        begin
          RAM_WE_O    <= 1'b1;
          RAM_ADDR_O  <= ram_addr(system_stack_pointer - 8'h01);
          RAM_WDATA_O <= pc_hold[15:8];
          system_stack_pointer         <= system_stack_pointer - `STKP_SSP_STEP;
          BUSY_O      <= 1'b0;
          state       <= ST_IDLE;
        end
        ST_RET1:
        begin
          RAM_RE_O   <= 1'b1;
          RAM_ADDR_O <= ram_addr(system_stack_pointer - 8'h01);
          state      <= ST_RET2;
        end
        ST_RET2:
        begin
          RAM_RE_O   <= 1'b1;
          RAM_ADDR_O <= ram_addr(system_stack_pointer);
          state      <= ST_RET3;
        end
        ST_RET3:
        begin
          pc_high <= RAM_RDATA_I;
          state   <= ST_RET4;
        end
        ST_RET4:
        begin
          PC_O      <= {pc_high, RAM_RDATA_I};
          PC_LOAD_O <= 1'b1;
          BUSY_O    <= 1'b0;
          state     <= ST_IDLE;
        end
        ST_POP1:
        begin
          state <= ST_POP2;
        end
        ST_POP2:
        begin
          POP_DATA_O  <= RAM_RDATA_I;
          POP_VALID_O <= 1'b1;
          BUSY_O      <= 1'b0;
          state       <= ST_IDLE;
        end
        default:
        begin
          BUSY_O <= 1'b0;
          state  <= ST_IDLE;
        end
      endcase
    end
  end

  // register read ports
  always @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      CFG_RDATA_O <= 8'h00;
      IN_RDATA_O  <= 8'h00;
    end
    else
    begin
      if (CFG_RADDR_I == `STKP_CFG_UST_PAGE)
        CFG_RDATA_O <= ust_page;
      else if (CFG_RADDR_I == `STKP_CFG_UST_LOC)
        CFG_RDATA_O <= ust_loc;
      else if (CFG_RADDR_I == `STKP_CFG_SSP_PAGE)
        CFG_RDATA_O <= `STKP_RAM_PAGE;
      else if (CFG_RADDR_I == `STKP_CFG_SSP_LOC)
        CFG_RDATA_O <= system_stack_pointer;
      else
        CFG_RDATA_O <= 8'h00;
      if (IN_RADDR_I == `STKP_IN_USP_PAGE)
        IN_RDATA_O <= `STKP_RAM_PAGE;
      else if (IN_RADDR_I == `STKP_IN_USP_LOC)
        IN_RDATA_O <= user_stack_pointer;
      else
        IN_RDATA_O <= 8'h00;
    end
  end
endmodule // stkp_top
`default_nettype wire

// file: verif/stkp_monitor.sv
// port checker for the stack block
// assumes binding into stkp_top
`timescale 1ns/1ps
`default_nettype none
module stkp_monitor
(
  input wire logic        CLK_I,
  input wire logic        RST_I,
  input wire logic        CALL_I,
  input wire logic        IRQ_I,
  input wire logic        SUB_RET_I,
  input wire logic        INT_RET_I,
  input wire logic        PUSH_I,
  input wire logic        POP_I,
  input wire logic [15:0] PC_I,
  input wire logic [7:0]  PUSH_DATA_I,
  input wire logic [7:0]  CFG_RADDR_I,
  input wire logic [7:0]  RAM_RDATA_I,
  input wire logic [7:0]  CFG_RDATA_O,
  input wire logic        RAM_WE_O,
  input wire logic        RAM_RE_O,
  input wire logic [15:0] RAM_ADDR_O,
  input wire logic [7:0]  RAM_WDATA_O,
  input wire logic [15:0] PC_O,
  input wire logic        PC_LOAD_O,
  input wire logic [7:0]  POP_DATA_O,
  input wire logic        POP_VALID_O,
  input wire logic        BUSY_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  wire rr = SUB_RET_I | INT_RET_I;
  wire sv = (CALL_I | IRQ_I) & ~BUSY_O;
  wire rt = rr & ~BUSY_O & ~sv;
  wire ps = PUSH_I & ~BUSY_O & ~sv & ~rr;
  wire pp = POP_I & ~PUSH_I & ~BUSY_O & ~sv & ~rr;
  sequence lo_s;
    RAM_WE_O && RAM_WDATA_O == $past(PC_I[7:0]);
  endsequence
  sequence hi_s;
    RAM_WE_O && RAM_WDATA_O == $past(PC_I[15:8], 2);
  endsequence
  call_wr_a: assert property (sv |=> lo_s ##1 hi_s)
    else $error("pc save wrong");
  call_step_a: assert property (sv |=> ##1
    RAM_ADDR_O[7:0] == $past(RAM_ADDR_O[7:0]) - 8'h01)
    else $error("pair order");
  ram_page_a: assert property ((RAM_WE_O || RAM_RE_O) |->
    RAM_ADDR_O[15:8] == 8'h20) else $error("page wrong");
  ret_load_a: assert property (rt |-> ##5 PC_LOAD_O &&
    PC_O == {$past(RAM_RDATA_I, 2), $past(RAM_RDATA_I)}) else $error("ret");
  pop_data_a: assert property (pp |-> ##3 POP_VALID_O &&
    POP_DATA_O == $past(RAM_RDATA_I)) else $error("pop data");
  push_wr_a: assert property (ps |=> RAM_WE_O &&
    RAM_WDATA_O == $past(PUSH_DATA_I)) else $error("push data");
  push_inc_a: assert property (ps ##1 ps |=>
    RAM_ADDR_O[7:0] == $past(RAM_ADDR_O[7:0]) + 8'h01)
    else $error("push step");
  ssp_page_a: assert property (!$past(RST_I) &&
    $past(CFG_RADDR_I) == 8'h2C |-> CFG_RDATA_O == 8'h20) else $error("pg");
endmodule // stkp_monitor
bind stkp_top stkp_monitor mon (.*);
`default_nettype wire

// file: verif/stkp_ram_model.sv
// one-page RAM seen by the stack block
// assumes one-cycle read, unread cycles show changing data
`timescale 1ns/1ps
`default_nettype none
module stkp_ram_model
(
  input  wire logic        clk_i,
  input  wire logic        we_i,
  input  wire logic        re_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  output var  logic [7:0]  rdata_o
);
  logic [7:0] mem [0:255];
  initial rdata_o = 8'h00;
  always @(posedge clk_i)
  begin
    if (we_i)
      mem[addr_i[7:0]] <= wdata_i;
    rdata_o <= re_i ? mem[addr_i[7:0]] : ~rdata_o;
  end
endmodule // stkp_ram_model
`default_nettype wire

// file: verif/stkp_tb.sv
// bench for the stack block
// assumes stkp_top, the RAM model and the checker
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
  miscompares++; $display("Error %0t: %h vs %h", $time, g, e); end end
module tb;
  logic        CLK_I = 1'b0;
  logic        RST_I = 1'b1;
  logic        CALL_I = 1'b0, IRQ_I = 1'b0, SUB_RET_I = 1'b0;
  logic        INT_RET_I = 1'b0, PUSH_I = 1'b0, POP_I = 1'b0;
  logic        CFG_WR_I = 1'b0;
  logic [2:0]  FLAGS_I = 3'h0;
  logic [15:0] PC_I = 16'h0000, pc_cap = 16'h0000;
  logic [7:0]  PUSH_DATA_I = 8'h00, CFG_ADDR_I = 8'h00, pop_cap = 8'h00;
  logic [7:0]  CFG_WDATA_I = 8'h00, CFG_RADDR_I = 8'h00, IN_RADDR_I = 8'h00;
  wire  [7:0]  CFG_RDATA_O, IN_RDATA_O, RAM_WDATA_O, POP_DATA_O, RAM_RDATA_I;
  wire         RAM_WE_O, RAM_RE_O, PC_LOAD_O, POP_VALID_O, BUSY_O;
  wire  [15:0] RAM_ADDR_O, PC_O;
  wire  [2:0]  FLAGS_O;
  int          miscompares = 0, checks_done = 0, cyc = 0;
  stkp_top DUT (.*);
  stkp_ram_model ram (.clk_i(CLK_I), .we_i(RAM_WE_O), .re_i(RAM_RE_O),
    .addr_i(RAM_ADDR_O), .wdata_i(RAM_WDATA_O), .rdata_o(RAM_RDATA_I));
  always #5 CLK_I = ~CLK_I;
  always @(posedge CLK_I)
  begin
    cyc <= cyc + 1;
    if (PC_LOAD_O === 1'b1)
      pc_cap <= PC_O;
    if (POP_VALID_O === 1'b1)
      pop_cap <= POP_DATA_O;
    if (cyc == 3000)
    begin
      miscompares++;
      end_sim;
    end
  end
  task end_sim;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic cmd(input [5:0] v, input [15:0] p);
    @(posedge CLK_I);
    {POP_I, PUSH_I, INT_RET_I, SUB_RET_I, IRQ_I, CALL_I} <= v;
    PC_I <= p;
    PUSH_DATA_I <= p[7:0];
    @(posedge CLK_I);
    {POP_I, PUSH_I, INT_RET_I, SUB_RET_I, IRQ_I, CALL_I} <= 6'h00;
    repeat (7) @(posedge CLK_I);
  endtask
  task automatic wcfg(input [7:0] a, input [7:0] d);
    @(posedge CLK_I);
    CFG_WR_I <= 1'b1;
    CFG_ADDR_I <= a;
    CFG_WDATA_I <= d;
    @(posedge CLK_I);
    CFG_WR_I <= 1'b0;
  endtask
  task automatic chk(input [7:0] a, input bit sp, input [7:0] e);
    @(posedge CLK_I);
    CFG_RADDR_I <= a;
    IN_RADDR_I <= a;
    repeat (2) @(posedge CLK_I);
    `CHK(sp ? IN_RDATA_O : CFG_RDATA_O, e)
  endtask
  task t_sys;
    cmd(6'h01, 16'h1234);
    FLAGS_I <= 3'h5;
    cmd(6'h02, 16'hABCD);
    FLAGS_I <= 3'h0;
    chk(8'h2D, 0, 8'hFB);
    `CHK({ram.mem[8'hFE], ram.mem[8'hFF]}, 16'h1234)
    cmd(6'h08, 16'h0000);
    `CHK(pc_cap, 16'hABCD)
    `CHK(FLAGS_O, 3'h5)
    cmd(6'h04, 16'h0000);
    `CHK(pc_cap, 16'h1234)
    chk(8'h2D, 0, 8'hFF);
    wcfg(8'h2D, 8'h80);
    wcfg(8'h2C, 8'h55);
    chk(8'h2C, 0, 8'h20);
    cmd(6'h01, 16'h5678);
    `CHK(ram.mem[8'h80], 8'h78)
    chk(8'h2D, 0, 8'h7E);
  endtask
  task t_user;
    wcfg(8'h05, 8'h40);
    wcfg(8'h06, 8'h10);
    chk(8'h0C, 1, 8'h10);
    @(posedge CLK_I);
    PUSH_I <= 1'b1;
    PUSH_DATA_I <= 8'hA1;
    @(posedge CLK_I);
    PUSH_DATA_I <= 8'hA2;
    @(posedge CLK_I);
    PUSH_I <= 1'b0;
    chk(8'h0C, 1, 8'h12);
    `CHK(ram.mem[8'h10], 8'hA1)
    cmd(6'h20, 16'h0000);
    `CHK(pop_cap, 8'hA2)
    cmd(6'h20, 16'h0000);
    `CHK(pop_cap, 8'hA1)
    chk(8'h0B, 1, 8'h20);
    wcfg(8'h06, 8'hFF);
    cmd(6'h10, 16'h0033);
    chk(8'h0C, 1, 8'h00);
  endtask
  initial
  begin
    repeat (16) @(posedge CLK_I);
    RST_I <= 1'b0;
    chk(8'h2D, 0, 8'hFF);
    chk(8'h0C, 1, 8'h00);
    t_sys;
    t_user;
    end_sim;
  end
endmodule // tb
`default_nettype wire
